// File: rtl/asp_top.sv
// Serial frame engine, register loading and power-mode control
// Contract
// - Power mode from two bits; start normal
// - Chip select fall: hold, convert, drive output
// - Frame is sixteen serial clock cycles
// - Back to track on rising edge fourteen; auto modes hold until deselect
// - Output released on falling edge sixteen
// - Early deselect aborts; late loads stay
// - Input sampled on falling edges; write-gated
// - First three bits pick the register
// - Twelve-bit control loads on falling fifteen
// - Range loads on falling edge eleven
// - Output: two zeros, channel, sign, result
// - Zeros on select fall, first falling
// - Registers kept through every power-down
// - Full shutdown at rising fifteen; sticky
// - Normal write wakes from full shutdown
// - Autoshutdown: down at fifteen, wake on deselect
// - Autoshutdown repeats after each conversion
// - Autostandby keeps reference powered
// - Autostandby: down at fifteen, wake on deselect
// - Reference select bit, cleared at reset
`include "asp_params.svh"
module asp_top
   import asp_pkg::*;
#(
   parameter logic [15:0] SD_WAKE_CYC =
      16'((`ASP_SD_WAKE_US * 1000) / `ASP_CLK_NS),
   parameter logic [15:0] FULL_WAKE_CYC =
      16'((`ASP_SD_WAKE_US * 1000) / `ASP_CLK_NS)
)(
   // System clock and reset
   input  wire logic        CLOCK,
   input  wire logic        RST,
   // Serial link
   input  wire logic        CS_N,
   input  wire logic        SCLK,
   input  wire logic        DIN,
   output logic             DOUT_O,
   output logic             DOUT_OE,
   // Converter core, on the serial clock
   input  wire logic        SAR_CHAN,
   input  wire logic        SAR_SIGN,
   input  wire logic [11:0] SAR_RESULT,
   output logic             HOLD,
   // Power and configuration state
   output logic [1:0]       POWER_MODE,
   output logic             CORE_ON,
   output logic             CORE_READY,
   output logic             REF_ON,
   output logic             REF_INTERNAL,
   output logic [11:0]      CTRL_WORD,
   output logic [1:0]       RANGE_CH0,
   output logic [1:0]       RANGE_CH1
);
   localparam logic [15:0] SB_WAKE_CYC =
      16'((`ASP_SB_WAKE_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS);

   asp_fall_t  fall_q, fall_d;
   asp_fkeep_t fkeep_q, fkeep_d;
   asp_rise_t  rise_q, rise_d;
   asp_rkeep_t rkeep_q, rkeep_d;
   asp_sys_t   sys_q, sys_d;
   logic [14:0] w15;
   logic [10:0] w11;
   logic       frame_ev;
   logic       range_ev;
   logic       cs_rise;
   logic [1:0] new_pm;
   logic [1:0] frame_pm;

   // ****************************************
   // Falling-edge frame logic
   // ****************************************
   assign w15 = {fall_q.rx[13:0], DIN};
   assign w11 = w15[10:0];

   always_comb begin
      fall_d = fall_q;
      fkeep_d = fkeep_q;
      if (fall_q.cnt != `ASP_FRAME_LEN) begin
         fall_d.cnt = fall_q.cnt + 5'h01;
      end
      fall_d.rx = w15;
      fall_d.dout = fall_q.sh[12];
      fall_d.sh = {fall_q.sh[11:0], 1'b0};
      unique case (fall_d.cnt)
         5'h01: begin
            fall_d.dout = 1'b0;
         end
         `ASP_RES_EDGE: begin
            fall_d.dout = SAR_CHAN;
            fall_d.sh = {SAR_SIGN, SAR_RESULT};
         end
         `ASP_RANGE_EDGE: begin
            // Range header lives in the top three bits
            if (w11[10:8] == `ASP_HDR_RANGE) begin
               fkeep_d.rword = {w11[7:6], w11[3:2]};
               fkeep_d.rtgl = ~fkeep_q.rtgl;
            end
         end
         `ASP_CTRL_EDGE: begin
            if (w15[14:12] == `ASP_HDR_CTRL) begin
               fkeep_d.cword = w15[11:0];
               fall_d.hit = 1'b1;
            end
         end
         `ASP_FRAME_LEN: begin
            fall_d.done = 1'b1;
         end
         default: begin
         end
      endcase
   end

   // Deselect clears the frame: a frame cut before its load edge never reaches it
   always_ff @(negedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         fall_q <= '0;
      end else begin
         fall_q <= fall_d;
      end
   end

   // Link clock may stop, so kept state resets on RST directly
   always_ff @(negedge SCLK or posedge RST) begin
      if (RST) begin
         fkeep_q <= '{`ASP_CTRL_RST, `ASP_RANGE_RST, 1'b0};
      end else begin
         fkeep_q <= fkeep_d;
      end
   end

   assign DOUT_O = fall_q.dout;
   // Pin-level enable: must follow select before any clock edge
   assign DOUT_OE = ~CS_N & ~fall_q.done;

   // ****************************************
   // Rising-edge frame logic
   // ****************************************
   always_comb begin
      rise_d = rise_q;
      rkeep_d = rkeep_q;
      rkeep_d.pm_m = sys_q.ctrl[`ASP_PM_HI:`ASP_PM_LO];
      rkeep_d.pm_s = rkeep_q.pm_m;
      if (rise_q.cnt != `ASP_FRAME_LEN) begin
         rise_d.cnt = rise_q.cnt + 5'h01;
      end
      // Auto modes hold until deselect, the entering write included
      if (rise_d.cnt == `ASP_TRACK_EDGE) begin
         rise_d.trk = (frame_pm == `ASP_PM_NORMAL) ||
                      (frame_pm == `ASP_PM_FULL);
      end
      if (rise_d.cnt == `ASP_PWR_EDGE) begin
         rkeep_d.etgl = ~rkeep_q.etgl;
         rkeep_d.ewr = fall_q.hit;
      end
   end

   always_ff @(posedge SCLK or posedge CS_N) begin
      if (CS_N) begin
         rise_q <= '0;
      end else begin
         rise_q <= rise_d;
      end
   end

   always_ff @(posedge SCLK or posedge RST) begin
      if (RST) begin
         rkeep_q <= '0;
      end else begin
         rkeep_q <= rkeep_d;
      end
   end

   assign HOLD = ~CS_N & ~rise_q.trk;
   // Mode bits of a control write are in by rising edge fourteen
   assign frame_pm = (fall_q.rx[13:11] == `ASP_HDR_CTRL) ? fall_q.rx[4:3] : rkeep_q.pm_s;

   // ****************************************
   // System-side power control
   // ****************************************
   // ewr and cword settle before the toggle is seen here
   assign frame_ev = sys_q.ev_s[1] ^ sys_q.ev_s[2];
   assign range_ev = sys_q.rg_s[1] ^ sys_q.rg_s[2];
   assign cs_rise = sys_q.cs_s[1] & ~sys_q.cs_s[2];
   assign new_pm = (frame_ev && rkeep_q.ewr) ?
      fkeep_q.cword[`ASP_PM_HI:`ASP_PM_LO] :
      sys_q.ctrl[`ASP_PM_HI:`ASP_PM_LO];

   always_comb begin
      sys_d = sys_q;
      sys_d.ev_s = {sys_q.ev_s[1:0], rkeep_q.etgl};
      sys_d.rg_s = {sys_q.rg_s[1:0], fkeep_q.rtgl};
      sys_d.cs_s = {sys_q.cs_s[1:0], CS_N};
      if (range_ev) begin
         sys_d.rng = fkeep_q.rword;
      end
      if (frame_ev && rkeep_q.ewr) begin
         sys_d.ctrl = fkeep_q.cword;
      end
      unique case (sys_q.st)
         PW_FULL: begin
            // Only a write changes the bits; contents kept
            if (frame_ev && new_pm == `ASP_PM_NORMAL) begin
               sys_d.st = PW_WAKE;
               sys_d.tmr = FULL_WAKE_CYC;
            end else if (frame_ev && new_pm != `ASP_PM_FULL) begin
               sys_d.st = PW_SLEEP;
            end
         end
         PW_SLEEP: begin
            // Select held low keeps the core asleep; deselect or a normal write wakes it
            if (frame_ev && new_pm == `ASP_PM_FULL) begin
               sys_d.st = PW_FULL;
            end else if (frame_ev && new_pm == `ASP_PM_NORMAL) begin
               sys_d.st = PW_WAKE;
               sys_d.tmr = (sys_q.ctrl[`ASP_PM_HI:`ASP_PM_LO] == `ASP_PM_SB) ?
                  SB_WAKE_CYC : SD_WAKE_CYC;
            end else if (cs_rise) begin
               sys_d.st = PW_WAKE;
               sys_d.tmr = (sys_q.ctrl[`ASP_PM_HI:`ASP_PM_LO] == `ASP_PM_SB) ?
                  SB_WAKE_CYC : SD_WAKE_CYC;
            end
         end
         default: begin
            if (sys_q.st == PW_WAKE) begin
               sys_d.tmr = sys_q.tmr - 16'h0001;
               if (sys_q.tmr <= 16'h0001) begin
                  sys_d.st = PW_RUN;
               end
            end
            if (frame_ev) begin
               unique case (new_pm)
                  `ASP_PM_FULL:   sys_d.st = PW_FULL;
                  `ASP_PM_SD:     sys_d.st = PW_SLEEP;
                  `ASP_PM_SB:     sys_d.st = PW_SLEEP;
                  `ASP_PM_NORMAL: sys_d.st = sys_q.st;
               endcase
            end
         end
      endcase
      sys_d.core_on = (sys_d.st == PW_RUN) || (sys_d.st == PW_WAKE);
      sys_d.ready = (sys_d.st == PW_RUN);
      sys_d.ref_on = sys_d.ctrl[`ASP_REF_BIT] &&
         (sys_d.core_on || (sys_d.st == PW_SLEEP &&
          sys_d.ctrl[`ASP_PM_HI:`ASP_PM_LO] == `ASP_PM_SB));
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         sys_q <= '0;
         sys_q.st <= PW_RUN;
         sys_q.ctrl <= `ASP_CTRL_RST;
         sys_q.rng <= `ASP_RANGE_RST;
         sys_q.cs_s <= 3'h7;
         sys_q.core_on <= 1'b1;
         sys_q.ready <= 1'b1;
      end else begin
         sys_q <= sys_d;
      end
   end

   assign POWER_MODE = sys_q.ctrl[`ASP_PM_HI:`ASP_PM_LO];
   assign CORE_ON = sys_q.core_on;
   assign CORE_READY = sys_q.ready;
   assign REF_ON = sys_q.ref_on;
   assign REF_INTERNAL = sys_q.ctrl[`ASP_REF_BIT];
   assign CTRL_WORD = sys_q.ctrl;
   assign RANGE_CH0 = sys_q.rng[3:2];
   assign RANGE_CH1 = sys_q.rng[1:0];

   // ****************************************
   // Checks
   // ****************************************
   chk_full_sticky: assert property (@(posedge CLOCK) disable iff (RST)
      (sys_q.st == PW_FULL && !frame_ev) |=> sys_q.st == PW_FULL)
      else $error("full shutdown left without a write");
   chk_sleep_wake: assert property (@(posedge CLOCK) disable iff (RST)
      (sys_q.st == PW_SLEEP && cs_rise && !frame_ev) |=> sys_q.st == PW_WAKE)
      else $error("no wake on deselect");
   chk_standby_wake: assert property (@(posedge CLOCK) disable iff (RST)
      ($rose(sys_q.st == PW_WAKE) && POWER_MODE == `ASP_PM_SB && !frame_ev)
      |-> ##27 (sys_q.st == PW_WAKE) ##1 (sys_q.st == PW_RUN))
      else $error("standby wake time wrong");
   chk_ctrl_load: assert property (@(posedge CLOCK) disable iff (RST)
      (frame_ev && rkeep_q.ewr) |=> CTRL_WORD == $past(fkeep_q.cword))
      else $error("control word not loaded");
   chk_full_off: assert property (@(posedge CLOCK) disable iff (RST)
      (sys_q.st == PW_FULL) |-> !CORE_ON && !REF_ON)
      else $error("power on in full shutdown");
   chk_ref_standby: assert property (@(posedge CLOCK) disable iff (RST)
      (sys_q.st == PW_SLEEP && POWER_MODE == `ASP_PM_SB && REF_INTERNAL) |-> REF_ON)
      else $error("reference off in standby");
   chk_out_release: assert property (@(posedge SCLK) disable iff (CS_N)
      (rise_q.cnt == 5'h0F) |-> !DOUT_OE)
      else $error("output still driven after frame");
   chk_lead_zero: assert property (@(posedge SCLK) disable iff (CS_N)
      (rise_q.cnt == 5'h00) |-> (!DOUT_O && DOUT_OE && fall_q.cnt == 5'h01))
      else $error("second leading zero wrong");
   chk_track_edge: assert property (@(posedge SCLK) disable iff (CS_N)
      (rise_q.cnt == 5'h0D && frame_pm == `ASP_PM_NORMAL) |=> rise_q.trk)
      else $error("no track at edge fourteen");
   chk_auto_hold: assert property (@(posedge SCLK) disable iff (CS_N)
      (rise_q.cnt == 5'h0D && (frame_pm[1] ^ frame_pm[0])) |=> !rise_q.trk)
      else $error("track in auto mode frame");
   chk_hold_select: assert property (@(posedge SCLK) disable iff (CS_N)
      (rise_q.cnt == 5'h00) |-> HOLD)
      else $error("not in hold after select");
   chk_oe_frame: assert property (@(negedge SCLK) disable iff (CS_N)
      (fall_q.cnt <= 5'h0E) |-> DOUT_OE)
      else $error("output released inside frame");
   chk_lead_drive: assert property (@(negedge SCLK) disable iff (CS_N)
      (fall_q.cnt == 5'h00) |-> (!DOUT_O && DOUT_OE))
      else $error("first leading zero wrong");
   chk_chan_bit: assert property (@(negedge SCLK) disable iff (CS_N)
      (fall_q.cnt == 5'h02) |-> DOUT_O == $past(SAR_CHAN))
      else $error("channel bit wrong");
   chk_sign_bit: assert property (@(negedge SCLK) disable iff (CS_N)
      (fall_q.cnt == 5'h03) |-> DOUT_O == $past(SAR_SIGN, 2))
      else $error("sign bit wrong");
   chk_ctrl_capture: assert property (@(negedge SCLK) disable iff (CS_N)
      (fall_q.cnt == 5'h0E && w15[14:12] == `ASP_HDR_CTRL) |=> fall_q.hit)
      else $error("control write not captured");
   chk_sleep_off: assert property (@(posedge CLOCK) disable iff (RST)
      (sys_q.st == PW_SLEEP) |-> (!CORE_ON && !CORE_READY))
      else $error("core on while asleep");
   chk_wake_busy: assert property (@(posedge CLOCK) disable iff (RST)
      (sys_q.st == PW_WAKE) |-> (CORE_ON && !CORE_READY))
      else $error("ready during power-up");
   chk_run_ready: assert property (@(posedge CLOCK) disable iff (RST)
      (sys_q.st == PW_RUN) |-> (CORE_ON && CORE_READY))
      else $error("not ready in normal run");
   chk_sd_ref_off: assert property (@(posedge CLOCK) disable iff (RST)
      (sys_q.st == PW_SLEEP && POWER_MODE == `ASP_PM_SD) |-> !REF_ON)
      else $error("reference on in autoshutdown");
   chk_ref_select: assert property (@(posedge CLOCK) disable iff (RST)
      !REF_INTERNAL |-> !REF_ON)
      else $error("internal reference on while deselected");
   chk_range_load: assert property (@(posedge CLOCK) disable iff (RST)
      range_ev |=> {RANGE_CH0, RANGE_CH1} == $past(fkeep_q.rword))
      else $error("range word not loaded");
   chk_ctrl_kept: assert property (@(posedge CLOCK) disable iff (RST)
      (!frame_ev || !rkeep_q.ewr) |=> $stable(CTRL_WORD))
      else $error("control word changed without write");
   chk_range_kept: assert property (@(posedge CLOCK) disable iff (RST)
      !range_ev |=> $stable({RANGE_CH0, RANGE_CH1}))
      else $error("range word changed without write");
   chk_full_enter: assert property (@(posedge CLOCK) disable iff (RST)
      (frame_ev && new_pm == `ASP_PM_FULL) |=> sys_q.st == PW_FULL)
      else $error("full shutdown not entered");
   chk_auto_enter: assert property (@(posedge CLOCK) disable iff (RST)
      (frame_ev && (new_pm[1] ^ new_pm[0]) && !(sys_q.st == PW_SLEEP && cs_rise)) |=> sys_q.st == PW_SLEEP)
      else $error("auto power-down not entered");
   chk_wake_hold: assert property (@(posedge CLOCK) disable iff (RST)
      (sys_q.st == PW_WAKE && !frame_ev && sys_q.tmr > 16'h0001) |=> sys_q.st == PW_WAKE)
      else $error("power-up ended early");
   cov_standby_ref: cover property (@(posedge CLOCK) disable iff (RST)
      sys_q.st == PW_SLEEP && REF_ON);
   cov_abort: cover property (@(posedge CS_N)
      rise_q.cnt != 5'h00 && rise_q.cnt < 5'h10);
   cov_full: cover property (@(posedge CLOCK) disable iff (RST)
      sys_q.st == PW_FULL ##1 sys_q.st == PW_WAKE);
   cov_sleep: cover property (@(posedge CLOCK) disable iff (RST)
      sys_q.st == PW_SLEEP ##1 sys_q.st == PW_WAKE);
   cov_range: cover property (@(posedge CLOCK) disable iff (RST) range_ev);
endmodule

// File: rtl/asp_params.svh
// Constants of the serial port and power-mode block
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
`define ASP_CLK_NS      25
`define ASP_SB_WAKE_NS  700
`define ASP_SD_WAKE_US  500
`define ASP_FRAME_LEN   5'h10
`define ASP_TRACK_EDGE  5'h0E
`define ASP_PWR_EDGE    5'h0F
`define ASP_CTRL_EDGE   5'h0F
`define ASP_RANGE_EDGE  5'h0B
`define ASP_RES_EDGE    5'h02
`define ASP_HDR_CTRL    3'h4
`define ASP_HDR_RANGE   3'h5
`define ASP_PM_HI       5
`define ASP_PM_LO       4
`define ASP_REF_BIT     2
`define ASP_PM_NORMAL   2'h0
`define ASP_PM_SB       2'h1
`define ASP_PM_SD       2'h2
`define ASP_PM_FULL     2'h3
`define ASP_CTRL_RST    12'h000
`define ASP_RANGE_RST   4'h0
`endif

// File: rtl/asp_pkg.sv
// Types of the serial port and power-mode block
package asp_pkg;
   typedef enum logic [1:0] {PW_RUN, PW_FULL, PW_SLEEP, PW_WAKE} asp_pw_t;
   typedef struct packed {
      logic [4:0]  cnt;
      logic [14:0] rx;
      logic [12:0] sh;
      logic        dout;
      logic        done;
      logic        hit;
   } asp_fall_t;
   typedef struct packed {
      logic [11:0] cword;
      logic [3:0]  rword;
      logic        rtgl;
   } asp_fkeep_t;
   typedef struct packed {
      logic [4:0] cnt;
      logic       trk;
   } asp_rise_t;
   typedef struct packed {
      logic [1:0] pm_m;
      logic [1:0] pm_s;
      logic       etgl;
      logic       ewr;
   } asp_rkeep_t;
   typedef struct packed {
      asp_pw_t     st;
      logic [15:0] tmr;
      logic [2:0]  ev_s;
      logic [2:0]  rg_s;
      logic [2:0]  cs_s;
      logic [11:0] ctrl;
      logic [3:0]  rng;
      logic        core_on;
      logic        ready;
      logic        ref_on;
   } asp_sys_t;
endpackage

// File: tb/asp_host_model.sv
// Host-side serial master that runs frames into the converter port
module asp_host_model
(
   // Serial link
   output logic      cs_n,
   output logic      sclk,
   output logic      din,
   input  wire logic dout_o,
   input  wire logic dout_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // Frame driver
   // ****************************************
   logic [15:0] rx;
   logic        oe_end;
   initial begin
      cs_n   = 1'b1;
      sclk   = 1'b1;
      din    = 1'b1;
      rx     = 16'h0000;
      oe_end = 1'b0;
   end
   // Clock stands high between frames; caller spaces frames for quiet time
   // MSB first, changed on rising edges so stable at falling
   // Short frames come only from abort scenarios; normal use gives sixteen
   task automatic frame(input logic [15:0] w, input int n, input bit keep);
      cs_n = 1'b0;
      for (int k = 0; k < n; k++) begin
         din = w[15-k];
         #3 rx[15-k] = dout_o;
         sclk = 1'b0;
         #1 oe_end = dout_oe;
         #2 sclk = 1'b1;
      end
      // Released line shows the inverse, never a stale level
      din = ~din;
      if (!keep) begin
         #3 cs_n = 1'b1;
      end
   endtask
   task automatic release_cs();
      cs_n = 1'b1;
   endtask
endmodule

// File: tb/adc_serial_port_power_modes_tb_top.sv
// Self-checking bench for the serial port and power-mode block
module adc_serial_port_power_modes_tb_top
   import asp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // Harness
   // ****************************************
   // Short wake counts keep the run brief
   localparam logic [15:0] WAKE = 16'h0028;
   logic        CLOCK, RST, CS_N, SCLK, DIN, DOUT_O, DOUT_OE, HOLD;
   logic        SAR_CHAN, SAR_SIGN, CORE_ON, CORE_READY, REF_ON, REF_INTERNAL;
   logic [11:0] SAR_RESULT, CTRL_WORD;
   logic [1:0]  POWER_MODE, RANGE_CH0, RANGE_CH1;
   int          fail_count = 0;
   int          compares = 0;
   asp_top #(.SD_WAKE_CYC(WAKE), .FULL_WAKE_CYC(WAKE)) asp_top_inst (.CLOCK(CLOCK), .RST(RST),
      .CS_N(CS_N), .SCLK(SCLK), .DIN(DIN), .DOUT_O(DOUT_O), .DOUT_OE(DOUT_OE), .SAR_CHAN(SAR_CHAN),
      .SAR_SIGN(SAR_SIGN), .SAR_RESULT(SAR_RESULT), .HOLD(HOLD), .POWER_MODE(POWER_MODE),
      .CORE_ON(CORE_ON), .CORE_READY(CORE_READY), .REF_ON(REF_ON), .REF_INTERNAL(REF_INTERNAL),
      .CTRL_WORD(CTRL_WORD), .RANGE_CH0(RANGE_CH0), .RANGE_CH1(RANGE_CH1));
   asp_host_model asp_host_model_inst (.cs_n(CS_N), .sclk(SCLK), .din(DIN), .dout_o(DOUT_O),
      .dout_oe(DOUT_OE));
   initial begin
      CLOCK = 1'b0;
      forever #12.5 CLOCK = ~CLOCK;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge CLOCK);
      #2;
   endtask
   // Control loads stay well over eight cycles apart
   task automatic send(input logic [15:0] w, input int n, input bit keep);
      cyc(1);
      asp_host_model_inst.frame(w, n, keep);
      cyc(10);
   endtask
   function automatic logic [15:0] cw(input logic [1:0] pm, input logic rf);
      logic [11:0] c;
      c = 12'h000;
      c[5:4] = pm;
      c[2] = rf;
      return {3'h4, c, 1'b0};
   endfunction
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      chk({POWER_MODE, CORE_ON, CORE_READY}, 4'h3);
      chk({REF_INTERNAL, CTRL_WORD}, 13'h0000);
      chk({RANGE_CH0, RANGE_CH1}, 4'h0);
      $display("test reset done");
   endtask
   task automatic t_read();
      send(16'h0000, 16, 1'b1);
      chk(asp_host_model_inst.rx, 16'h2A5C);
      chk(asp_host_model_inst.oe_end, 1'b0);
      chk({HOLD, DOUT_OE}, 2'h0);
      chk(CTRL_WORD, 12'h000);
      asp_host_model_inst.release_cs();
      cyc(4);
      $display("test read done");
   endtask
   task automatic t_abort();
      send(cw(2'h0, 1'b1), 13, 1'b1);
      chk({HOLD, DOUT_OE, asp_host_model_inst.oe_end}, 3'h7);
      asp_host_model_inst.release_cs();
      cyc(10);
      chk({DOUT_OE, CTRL_WORD}, 13'h0000);
      send(16'hB080, 12, 1'b0);
      chk({RANGE_CH0, RANGE_CH1, CTRL_WORD}, 16'h9000);
      send(16'hA980, 16, 1'b0);
      chk({RANGE_CH0, RANGE_CH1}, 4'h7);
      $display("test abort done");
   endtask
   task automatic t_full();
      send(cw(2'h0, 1'b1), 16, 1'b0);
      chk({REF_INTERNAL, CTRL_WORD}, 13'h1004);
      send(cw(2'h3, 1'b1), 16, 1'b0);
      chk({POWER_MODE, CORE_ON, CORE_READY}, 4'hC);
      send(16'h0000, 16, 1'b0);
      chk({CORE_ON, CTRL_WORD}, 13'h0034);
      send(cw(2'h0, 1'b1), 16, 1'b0);
      chk({CORE_ON, CORE_READY}, 2'h2);
      cyc(40);
      chk(CORE_READY, 1'b1);
      $display("test full shutdown done");
   endtask
   // Standby wakes in 28 cycles, shutdown in 40: the check at 35 tells them apart
   task automatic t_auto(input logic [1:0] pm);
      send(cw(pm, 1'b1), 16, 1'b1);
      chk({HOLD, CORE_ON, REF_ON}, {2'b10, pm[0]});
      asp_host_model_inst.release_cs();
      cyc(6);
      chk({HOLD, CORE_ON, CORE_READY}, 3'h2);
      cyc(29);
      chk(CORE_READY, pm[0]);
      cyc(15);
      chk(CORE_READY, 1'b1);
      // Host has waited past the wake time
      send(16'h0000, 16, 1'b1);
      chk({CORE_ON, POWER_MODE}, {1'b0, pm});
      asp_host_model_inst.release_cs();
      cyc(50);
      $display("test auto mode %0d done", pm);
   endtask
   initial begin
      RST = 1'b1;
      SAR_CHAN = 1'b1;
      SAR_SIGN = 1'b0;
      SAR_RESULT = 12'hA5C;
      repeat (8) @(posedge CLOCK);
      #2 RST = 1'b0;
      cyc(4);
      t_reset();
      t_read();
      t_abort();
      t_full();
      t_auto(2'h2);
      t_auto(2'h1);
      finish_test();
   end
   // Whole run is about 450 cycles
   initial begin
      #100000;
      fail_count++;
      finish_test();
   end
endmodule
